// >>> hw/cit_pkg.sv
package cit_pkg;

   localparam logic [7:0]  OFS_CFG        = 8'h00;
   localparam logic [7:0]  OFS_BASE       = 8'h04;
   localparam logic [7:0]  OFS_STAT       = 8'h08;
   localparam int          CFG_VEC_BIT    = 0;
   localparam int          STAT_NMI_BIT   = 7;
   localparam int          STAT_LVEC_LSB  = 8;
   localparam logic        RST_CFG_VEC    = 1'b0;
   localparam logic [23:0] RST_BASE       = 24'h000000;

   localparam logic [23:0] ADDR_NMI_ACK   = 24'hffff00;
   localparam logic [23:0] ADDR_MASTER    = 24'hfffe00;
   localparam logic [3:0]  STAT_ACK_M     = 4'h4;
   localparam logic [3:0]  STAT_ACK_C     = 4'h5;
   localparam logic [3:0]  STAT_EOI_M     = 4'h6;
   localparam logic [3:0]  STAT_EOI_C     = 4'h7;
   localparam logic [3:0]  STAT_MEM_RD    = 4'h8;

   localparam logic [7:0]  VEC_NONVEC     = 8'h00;
   localparam logic [7:0]  VEC_NMI        = 8'h01;
   localparam logic [7:0]  VEC_SLAVE      = 8'h03;
   localparam logic [7:0]  VEC_PRIV       = 8'h04;
   localparam logic [7:0]  VEC_SVC        = 8'h05;
   localparam logic [7:0]  VEC_DVZ        = 8'h06;
   localparam logic [7:0]  VEC_FLAG       = 8'h07;
   localparam logic [7:0]  VEC_BPT        = 8'h08;
   localparam logic [7:0]  VEC_STEP       = 8'h09;
   localparam logic [7:0]  VEC_UND        = 8'h0a;

   localparam logic [1:0]  K_NMI          = 2'h0;
   localparam logic [1:0]  K_NONVEC       = 2'h1;
   localparam logic [1:0]  K_VEC          = 2'h2;
   localparam logic [1:0]  K_EOI          = 2'h3;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_MACK = 6'h02,
      S_TBL  = 6'h04,
      S_CACK = 6'h08,
      S_EOIM = 6'h10,
      S_EOIC = 6'h20
   } cit_state_type;

   typedef struct packed {
      logic irq_en;
      logic user;
      logic trace_pend;
      logic flag;
   } cit_psr_type;

   typedef struct packed {
      logic slave_err;
      logic priv_op;
      logic supervisor_call_trap;
      logic div_zero;
      logic flag_op;
      logic breakpoint_trap;
      logic undef;
   } cit_trap_type;

   typedef struct packed {
      logic        valid;
      logic        irq_off;
      logic [7:0]  vec;
      logic [23:0] disp;
      logic [23:0] ret;
   } cit_exc_type;

   typedef struct packed {
      logic        req;
      logic        dword;
      logic [3:0]  status;
      logic [23:0] addr;
   } cit_ext_type;

   typedef struct packed {
      cit_state_type state;
      logic [1:0]    kind;
      logic          nmi_prev;
      logic          nmi_pend;
      logic          cfg_vec;
      logic [23:0]   base;
      logic [23:0]   ret_pc;
      logic [7:0]    last_vec;
      logic          ahb_wr;
      logic [7:0]    ahb_ofs;
      logic [31:0]   hrdata;
      logic          hready;
      logic          ret_done;
      logic          busy;
      cit_exc_type   exc;
      cit_ext_type   ext;
   } cit_st_type;

   localparam cit_st_type ST_RST = '{
      state    : S_IDLE,
      nmi_prev : 1'b1,
      hready   : 1'b1,
      cfg_vec  : RST_CFG_VEC,
      base     : RST_BASE,
      default  : '0
   };

endpackage

// >>> hw/cit_unit.sv
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cit_unit (
   input  wire logic                 clk_in,
   input  wire logic                 sys_rst_in,
   // AHB-Lite slave
   input  wire logic                 hsel_in,
   input  wire logic [31:0]          haddr_in,
   input  wire logic [1:0]           htrans_in,
   input  wire logic                 hwrite_in,
   input  wire logic [2:0]           hsize_in,
   input  wire logic [31:0]          hwdata_in,
   input  wire logic                 hready_in,
   output logic                      hreadyout_out,
   output logic                      hresp_out,
   output logic [31:0]               hrdata_out,
   // Pins
   input  wire logic                 irq_n_in,
   input  wire logic                 nmi_n_in,
   // Core side
   input  wire logic                 boundary_in,
   input  wire logic                 exec_check_in,
   input  wire logic [23:0]          pc_in,
   input  wire cit_pkg::cit_psr_type psr_in,
   input  wire cit_pkg::cit_trap_type traps_in,
   input  wire logic                 ret_irq_in,
   input  wire logic                 ret_exc_in,
   output cit_pkg::cit_exc_type      exc_out,
   output logic                      ret_done_out,
   output logic                      busy_out,
   // Acknowledge bus master
   output cit_pkg::cit_ext_type      ext_out,
   input  wire logic                 ext_ack_in,
   input  wire logic [31:0]          ext_rdata_in
);

   cit_pkg::cit_st_type q;
   cit_pkg::cit_st_type d;
   logic                nmi_fall;
   logic                take_nmi;
   logic [7:0]          rd_byte;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Report an exception to the core with its dispatch entry address
   function automatic cit_pkg::cit_st_type finish(
      input cit_pkg::cit_st_type s,
      input logic [7:0]          v,
      input logic [23:0]         ret,
      input logic                off
   );
      cit_pkg::cit_st_type r;
      r             = s;
      r.exc.valid   = 1'b1;
      r.exc.vec     = v;
      r.exc.disp    = s.base + {14'h0000, v, 2'b00};
      r.exc.ret     = ret;
      r.exc.irq_off = off;
      r.last_vec    = v;
      r.state       = cit_pkg::S_IDLE;
      r.ext.req     = 1'b0;
      return r;
   endfunction

   // Start one acknowledge, end or table cycle on the external bus
   function automatic cit_pkg::cit_st_type launch(
      input cit_pkg::cit_st_type   s,
      input logic [23:0]           a,
      input logic [3:0]            st,
      input logic                  dw,
      input cit_pkg::cit_state_type nx
   );
      cit_pkg::cit_st_type r;
      r            = s;
      r.ext.req    = 1'b1;
      r.ext.addr   = a;
      r.ext.status = st;
      r.ext.dword  = dw;
      r.state      = nx;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d            = q;
      d.exc.valid  = 1'b0;
      d.ret_done   = 1'b0;
      d.hready     = 1'b1;
      d.nmi_prev   = nmi_n_in;
      nmi_fall     = q.nmi_prev & ~nmi_n_in;
      take_nmi     = 1'b0;
      rd_byte      = ext_rdata_in[7:0];

      // Bus write lands in the data phase
      if (q.ahb_wr) begin
         case (q.ahb_ofs)
            cit_pkg::OFS_CFG: begin
               d.cfg_vec = hwdata_in[cit_pkg::CFG_VEC_BIT];
            end
            cit_pkg::OFS_BASE: begin
               d.base = {hwdata_in[23:2], 2'b00};
            end
            default: begin
               d.cfg_vec = d.cfg_vec;
            end
         endcase
      end

      // Address phase; reads see a write still in its data phase
      d.ahb_wr = 1'b0;
      if (hsel_in && htrans_in[1] && hready_in) begin
         d.ahb_wr  = hwrite_in;
         d.ahb_ofs = haddr_in[7:0];
         if (!hwrite_in) begin
            case (haddr_in[7:0])
               cit_pkg::OFS_CFG: begin
                  d.hrdata = {31'h00000000, d.cfg_vec};
               end
               cit_pkg::OFS_BASE: begin
                  d.hrdata = {8'h00, d.base};
               end
               cit_pkg::OFS_STAT: begin
                  d.hrdata = {16'h0000, q.last_vec, q.nmi_pend,
                              1'b0, q.state};
               end
               default: begin
                  d.hrdata = 32'h00000000;
               end
            endcase
         end
      end

      case (q.state)
         cit_pkg::S_IDLE: begin
            if (ret_irq_in) begin
               d.kind = cit_pkg::K_EOI;
               d = launch(d, cit_pkg::ADDR_MASTER, cit_pkg::STAT_EOI_M,
                          1'b0, cit_pkg::S_EOIM);
            end else if (ret_exc_in) begin
               d.ret_done = 1'b1;
            end else if (boundary_in) begin
               d.ret_pc = pc_in;
               if (q.nmi_pend) begin
                  take_nmi = 1'b1;
                  d.kind   = cit_pkg::K_NMI;
                  d = launch(d, cit_pkg::ADDR_NMI_ACK, cit_pkg::STAT_ACK_M,
                             1'b0, cit_pkg::S_MACK);
               end else if (!irq_n_in && psr_in.irq_en) begin
                  d.kind = q.cfg_vec ? cit_pkg::K_VEC
                                     : cit_pkg::K_NONVEC;
                  d = launch(d, cit_pkg::ADDR_MASTER, cit_pkg::STAT_ACK_M,
                             1'b0, cit_pkg::S_MACK);
               end else if (psr_in.trace_pend) begin
                  d = finish(d, cit_pkg::VEC_STEP, pc_in, 1'b0);
               end
            end else if (exec_check_in) begin
               // Seven exclusive traps, first one wins
               if (traps_in.slave_err) begin
                  d = finish(d, cit_pkg::VEC_SLAVE, pc_in, 1'b0);
               end else if (traps_in.priv_op && psr_in.user) begin
                  d = finish(d, cit_pkg::VEC_PRIV, pc_in, 1'b0);
               end else if (traps_in.supervisor_call_trap) begin
                  d = finish(d, cit_pkg::VEC_SVC, pc_in, 1'b0);
               end else if (traps_in.div_zero) begin
                  d = finish(d, cit_pkg::VEC_DVZ, pc_in, 1'b0);
               end else if (traps_in.flag_op && psr_in.flag) begin
                  d = finish(d, cit_pkg::VEC_FLAG, pc_in, 1'b0);
               end else if (traps_in.breakpoint_trap) begin
                  d = finish(d, cit_pkg::VEC_BPT, pc_in, 1'b0);
               end else if (traps_in.undef) begin
                  d = finish(d, cit_pkg::VEC_UND, pc_in, 1'b0);
               end
            end
         end

         cit_pkg::S_MACK: begin
            if (ext_ack_in) begin
               if (q.kind == cit_pkg::K_NMI) begin
                  d = finish(d, cit_pkg::VEC_NMI, q.ret_pc, 1'b1);
               end else if (q.kind == cit_pkg::K_NONVEC) begin
                  d = finish(d, cit_pkg::VEC_NONVEC, q.ret_pc, 1'b1);
               end else if (!rd_byte[7]) begin
                  d = finish(d, rd_byte, q.ret_pc, 1'b1);
               end else begin
                  d = launch(d, q.base + {{14{rd_byte[7]}}, rd_byte, 2'b00},
                             cit_pkg::STAT_MEM_RD, 1'b1,
                             cit_pkg::S_TBL);
               end
            end
         end

         cit_pkg::S_TBL: begin
            // Entry holds the cascaded controller's vector address
            if (ext_ack_in) begin
               if (q.kind == cit_pkg::K_EOI) begin
                  d = launch(d, ext_rdata_in[23:0], cit_pkg::STAT_EOI_C,
                             1'b0, cit_pkg::S_EOIC);
               end else begin
                  d = launch(d, ext_rdata_in[23:0], cit_pkg::STAT_ACK_C,
                             1'b0, cit_pkg::S_CACK);
               end
            end
         end

         cit_pkg::S_CACK: begin
            if (ext_ack_in) begin
               d = finish(d, rd_byte, q.ret_pc, 1'b1);
            end
         end

         cit_pkg::S_EOIM: begin
            if (ext_ack_in) begin
               if (rd_byte[7]) begin
                  d = launch(d, q.base + {{14{rd_byte[7]}}, rd_byte, 2'b00},
                             cit_pkg::STAT_MEM_RD, 1'b1,
                             cit_pkg::S_TBL);
               end else begin
                  d.ext.req  = 1'b0;
                  d.ret_done = 1'b1;
                  d.state    = cit_pkg::S_IDLE;
               end
            end
         end

         cit_pkg::S_EOIC: begin
            if (ext_ack_in) begin
               d.ext.req  = 1'b0;
               d.ret_done = 1'b1;
               d.state    = cit_pkg::S_IDLE;
            end
         end

         default: begin
            d = cit_pkg::ST_RST;
         end
      endcase

      // An edge in the cycle it is taken stays pending
      d.nmi_pend = nmi_fall | (q.nmi_pend & ~take_nmi);
      d.busy     = (d.state != cit_pkg::S_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         q <= cit_pkg::ST_RST;
      end else begin
         q <= d;
      end
   end

   assign hreadyout_out = q.hready;
   assign hresp_out     = 1'b0;
   assign hrdata_out    = q.hrdata;
   assign exc_out       = q.exc;
   assign ret_done_out  = q.ret_done;
   assign busy_out      = q.busy;
   assign ext_out       = q.ext;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   nmi_ack_addr_a: assert property (
      q.state == cit_pkg::S_MACK && q.kind == cit_pkg::K_NMI |->
         q.ext.addr == 24'hffff00 && q.ext.status == 4'h4 && q.ext.req)
      else $error("Non-maskable acknowledge address or status wrong");

   nmi_vector_one_a: assert property (
      q.state == cit_pkg::S_MACK && q.kind == cit_pkg::K_NMI &&
      ext_ack_in |=> q.exc.valid && q.exc.vec == 8'h01 && q.exc.irq_off)
      else $error("Non-maskable vector not one");

   nonvec_zero_a: assert property (
      q.state == cit_pkg::S_MACK && q.kind == cit_pkg::K_NONVEC &&
      ext_ack_in |=> q.exc.valid && q.exc.vec == 8'h00)
      else $error("Non-vectored request did not use vector zero");

   vec_byte_a: assert property (
      q.state == cit_pkg::S_MACK && q.kind == cit_pkg::K_VEC &&
      ext_ack_in && !ext_rdata_in[7] |=>
         q.exc.valid && q.exc.vec == $past(ext_rdata_in[7:0]))
      else $error("Vectored request did not take low data byte");

   casc_status_a: assert property (
      q.state == cit_pkg::S_CACK |-> q.ext.status == 4'h5 && q.ext.req)
      else $error("Cascaded acknowledge status wrong");

   table_addr_a: assert property (
      q.state == cit_pkg::S_MACK && ext_ack_in && ext_rdata_in[7] &&
      q.kind == cit_pkg::K_VEC |=> q.state == cit_pkg::S_TBL &&
         q.ext.dword && q.ext.addr == $past(q.base) -
         24'(($past(ext_rdata_in[7:0]) ^ 8'hff) + 9'h001) * 24'h000004)
      else $error("Cascade table entry address wrong");

   eoi_no_casc_a: assert property (
      q.state == cit_pkg::S_EOIM && ext_ack_in && !ext_rdata_in[7] |=>
         q.state == cit_pkg::S_IDLE && q.ret_done && !q.ext.req)
      else $error("Cascaded end cycle after positive vector");

   dispatch_a: assert property (
      q.exc.valid |->
         q.exc.disp == q.base + {14'h0000, q.exc.vec, 2'b00})
      else $error("Dispatch entry address wrong");

   trap_keeps_irq_a: assert property (
      q.state == cit_pkg::S_IDLE && !ret_irq_in && !ret_exc_in &&
      !boundary_in && exec_check_in && traps_in.undef |=>
         q.exc.valid && !q.exc.irq_off && q.exc.ret == $past(pc_in))
      else $error("Trap disabled interrupts or bad return address");

   priv_trap_a: assert property (
      q.state == cit_pkg::S_IDLE && !ret_irq_in && !ret_exc_in &&
      !boundary_in && exec_check_in && !traps_in.slave_err &&
      traps_in.priv_op && psr_in.user |=> q.exc.valid && q.exc.vec == 8'h04)
      else $error("Privileged operation in user mode not trapped");

   nmi_first_a: assert property (
      q.state == cit_pkg::S_IDLE && !ret_irq_in && !ret_exc_in &&
      boundary_in && q.nmi_pend |=> q.ext.addr == 24'hffff00
         ##1 q.ext.req [*1])
      else $error("Non-maskable request not served first");

   return_from_exception_op_quiet_a: assert property (
      q.state == cit_pkg::S_IDLE && !ret_irq_in && ret_exc_in |=>
         q.ret_done && !q.ext.req)
      else $error("Return from exception produced a bus cycle");

   master_ack_a: assert property (
      q.state == cit_pkg::S_MACK && q.kind != cit_pkg::K_NMI |->
         q.ext.addr == 24'hfffe00 && q.ext.status == 4'h4 && q.ext.req)
      else $error("Master acknowledge address or status wrong");

   casc_eoi_a: assert property (
      q.state == cit_pkg::S_EOIC |->
         q.ext.status == 4'h7 && q.ext.req && !q.ext.dword)
      else $error("Cascaded end cycle status wrong");

   nmi_edge_a: assert property (
      $fell(nmi_n_in) |=> q.nmi_pend)
      else $error("Falling edge on non-maskable pin not held pending");

   irq_masked_a: assert property (
      q.state == cit_pkg::S_IDLE && !ret_irq_in && !ret_exc_in &&
      boundary_in && !q.nmi_pend && !psr_in.irq_en |=>
         !q.ext.req && q.state == cit_pkg::S_IDLE)
      else $error("Maskable request taken while disabled");

   irq_before_step_a: assert property (
      q.state == cit_pkg::S_IDLE && !ret_irq_in && !ret_exc_in &&
      boundary_in && !q.nmi_pend && !irq_n_in && psr_in.irq_en |=>
         q.state == cit_pkg::S_MACK && !q.exc.valid)
      else $error("Maskable request not served before single step");

   step_trap_a: assert property (
      q.state == cit_pkg::S_IDLE && !ret_irq_in && !ret_exc_in &&
      boundary_in && !q.nmi_pend && (irq_n_in || !psr_in.irq_en) &&
      psr_in.trace_pend |=> q.exc.valid && q.exc.vec == 8'h09 &&
         !q.exc.irq_off && q.exc.ret == $past(pc_in))
      else $error("Single step trap missing or wrong");

   cov_nmi_c: cover property (
      q.state == cit_pkg::S_MACK && q.kind == cit_pkg::K_NMI && ext_ack_in);
   cov_cascade_c: cover property (
      q.state == cit_pkg::S_CACK && ext_ack_in);
   cov_eoi_casc_c: cover property (
      q.state == cit_pkg::S_EOIC && ext_ack_in);
   cov_step_c: cover property (
      q.exc.valid && q.exc.vec == 8'h09);
   cov_nonvec_c: cover property (
      q.state == cit_pkg::S_MACK && q.kind == cit_pkg::K_NONVEC && ext_ack_in);

endmodule // cit_unit

// >>> verification/cit_ctrl_model.sv
`timescale 1ns/1ps
module cit_ctrl_model (
   input  wire logic                 clk_in,
   input  wire logic                 sys_rst_in,
   input  wire cit_pkg::cit_ext_type ext_in,
   input  wire logic [3:0]           delay_in,
   input  wire logic [7:0]           mbyte_in,
   input  wire logic [7:0]           cbyte_in,
   input  wire logic [23:0]          tbl_addr_in,
   input  wire logic [31:0]          tbl_data_in,
   output logic                      ack_out,
   output logic [31:0]               rdata_out
);
   logic [3:0]  cnt_q;
   logic [31:0] junk_q;
   logic [31:0] ans;
   ////////////////////////////////////////////////////////////////////////////
   // Upper bytes of acknowledge and end cycles carry junk so only the low byte may be used
   always_comb begin
      case (ext_in.status)
         cit_pkg::STAT_ACK_M, cit_pkg::STAT_EOI_M: begin
            ans = {junk_q[31:8], mbyte_in};
         end
         cit_pkg::STAT_MEM_RD: begin
            ans = (ext_in.addr == tbl_addr_in) ? tbl_data_in : junk_q;
         end
         default: begin
            ans = {junk_q[31:8], cbyte_in};
         end
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cnt_q <= 4'h0;
         ack_out <= 1'b0;
         rdata_out <= 32'h0;
         junk_q <= 32'h5a3c96e1;
      end else begin
         junk_q <= ~junk_q + 32'h01030507;
         ack_out <= 1'b0;
         rdata_out <= junk_q;
         if (ext_in.req && !ack_out) begin
            if (cnt_q == delay_in) begin
               cnt_q <= 4'h0;
               ack_out <= 1'b1;
               rdata_out <= ans;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end
endmodule // cit_ctrl_model

// >>> verification/cit_unit_test.sv
`timescale 1ns/1ps
module cit_unit_test;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
   logic boundary_in = 1'b0, exec_check_in = 1'b0, ret_irq_in = 1'b0;
   logic ret_exc_in = 1'b0, irq_n_in = 1'b1, nmi_n_in = 1'b1;
   logic [31:0] haddr_in = '0, hwdata_in = '0, hrdata_out, ext_rdata_in;
   logic [1:0]  htrans_in = 2'h0;
   logic [2:0]  hsize_in = 3'h2;
   logic        hready_in, hreadyout_out, hresp_out, ret_done_out, busy_out;
   logic        ext_ack_in;
   logic [23:0] pc_in = 24'h001230;
   logic [3:0]  delay_in = 4'h0;
   logic [7:0]  mbyte_in = 8'h77, cbyte_in = 8'hc8;
   logic [23:0] tbl_addr_in = 24'h000fc0;
   logic [31:0] tbl_data_in = 32'h55ab1230;
   logic [31:0] cyc_q[$];
   logic [31:0] rd;
   int          n_fail = 0, checks = 0;
   cit_pkg::cit_psr_type  psr_in = '0;
   cit_pkg::cit_trap_type traps_in = '0;
   cit_pkg::cit_exc_type  exc_out;
   cit_pkg::cit_ext_type  ext_out;
   logic [7:0]  trap_vec [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a};

   assign hready_in = hreadyout_out;
   always #2 clk_in = ~clk_in;

   cit_unit i_cit_unit (.clk_in, .sys_rst_in, .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hreadyout_out,
      .hresp_out, .hrdata_out, .irq_n_in, .nmi_n_in, .boundary_in,
      .exec_check_in, .pc_in, .psr_in, .traps_in, .ret_irq_in, .ret_exc_in,
      .exc_out, .ret_done_out, .busy_out, .ext_out, .ext_ack_in, .ext_rdata_in);
   cit_ctrl_model i_cit_ctrl_model (.clk_in, .sys_rst_in, .ext_in(ext_out),
      .delay_in, .mbyte_in, .cbyte_in, .tbl_addr_in, .tbl_data_in,
      .ack_out(ext_ack_in), .rdata_out(ext_rdata_in));

   // Log of finished external bus cycles
   always @(posedge clk_in) begin
      if (ext_ack_in && ext_out.req)
         cyc_q.push_back({3'h0, ext_out.dword, ext_out.status, ext_out.addr});
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_cyc(input int n, input logic [3:0] st, input logic dw,
                          input logic [23:0] a);
      chk("bus cycle", {3'h0, dw, st, a}, n < cyc_q.size() ? cyc_q[n] : '1);
   endtask
   task automatic chk_exc(input logic [7:0] v, input logic off);
      chk("vector", {24'h0, v}, {24'h0, exc_out.vec});
      chk("dispatch", {8'h0, 24'h001000 + {14'h0, v, 2'b0}}, {8'h0, exc_out.disp});
      chk("return", {8'h0, pc_in}, {8'h0, exc_out.ret});
      chk("irq off", {31'h0, off}, {31'h0, exc_out.irq_off});
   endtask
   task automatic ahb(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rdv);
      @(posedge clk_in);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      haddr_in <= {24'h0, ofs};
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      htrans_in <= 2'h0;
      hsel_in <= 1'b0;
      hwdata_in <= wd;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      rdv = hrdata_out;
      chk("hresp", 32'h0, {31'h0, hresp_out});
   endtask
   // Core request pulse: 0 boundary, 1 trap check, 2 irq return, 3 exc return
   task automatic pulse(input int k, input logic irq, input logic [3:0] processor_status_word,
                        input logic [6:0] trp);
      cyc_q.delete();
      @(posedge clk_in);
      irq_n_in <= irq;
      psr_in <= processor_status_word;
      traps_in <= trp;
      pc_in <= pc_in + 24'h000014;
      boundary_in <= (k == 0);
      exec_check_in <= (k == 1);
      ret_irq_in <= (k == 2);
      ret_exc_in <= (k == 3);
      @(posedge clk_in);
      {boundary_in, exec_check_in, ret_irq_in, ret_exc_in} <= 4'h0;
   endtask
   task automatic wait_done(input int k, input int n);
      int i;
      i = 0;
      #1;
      chk("busy", {31'h0, n > 0}, {31'h0, busy_out});
      while ((k ? ret_done_out : exc_out.valid) !== 1'b1 && i < 100) begin
         @(posedge clk_in);
         #1;
         i++;
      end
      chk("completion", 32'h1, {31'h0, i < 100});
      chk("busy end", 32'h0, {31'h0, busy_out});
      chk("bus cycle count", n, cyc_q.size());
   endtask
   task automatic no_exc;
      logic seen;
      seen = 1'b0;
      repeat (10) begin
         @(posedge clk_in);
         #1;
         seen = seen | (exc_out.valid === 1'b1);
      end
      chk("no exception", 32'h0, {31'h0, seen});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      ahb(1'b0, cit_pkg::OFS_CFG, 32'h0, rd);
      chk("cfg reset", 32'h0, rd);
      ahb(1'b1, cit_pkg::OFS_BASE, 32'hff001003, rd);
      ahb(1'b0, cit_pkg::OFS_BASE, 32'h0, rd);
      chk("base", 32'h00001000, rd);
      ahb(1'b1, 8'h0c, 32'hffffffff, rd);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      ahb(1'b1, cit_pkg::OFS_STAT, 32'hffffffff, rd);
      ahb(1'b0, cit_pkg::OFS_STAT, 32'h0, rd);
      chk("status", 32'h00000001, rd);
   endtask
   task automatic t_irq;
      pulse(0, 1'b0, 4'b1000, 7'h0);
      wait_done(0, 1);
      chk_exc(8'h00, 1'b1);
      chk_cyc(0, cit_pkg::STAT_ACK_M, 1'b0, cit_pkg::ADDR_MASTER);
      pulse(0, 1'b0, 4'b0000, 7'h0);
      no_exc();
      ahb(1'b1, cit_pkg::OFS_CFG, 32'h1, rd);
      delay_in <= 4'h3;
      mbyte_in <= 8'h25;
      repeat (2) begin
         pulse(0, 1'b0, 4'b1010, 7'h0);
         wait_done(0, 1);
         chk_exc(8'h25, 1'b1);
      end
      delay_in <= 4'h2;
      mbyte_in <= 8'hf0;
      pulse(0, 1'b0, 4'b1000, 7'h0);
      wait_done(0, 3);
      chk_exc(8'hc8, 1'b1);
      chk_cyc(1, cit_pkg::STAT_MEM_RD, 1'b1, 24'h000fc0);
      chk_cyc(2, cit_pkg::STAT_ACK_C, 1'b0, 24'hab1230);
      pulse(2, 1'b1, 4'b0000, 7'h0);
      wait_done(1, 3);
      chk_cyc(0, cit_pkg::STAT_EOI_M, 1'b0, cit_pkg::ADDR_MASTER);
      chk_cyc(1, cit_pkg::STAT_MEM_RD, 1'b1, 24'h000fc0);
      chk_cyc(2, cit_pkg::STAT_EOI_C, 1'b0, 24'hab1230);
      mbyte_in <= 8'h25;
      pulse(2, 1'b1, 4'b0000, 7'h0);
      wait_done(1, 1);
   endtask
   task automatic t_nmi;
      @(posedge clk_in);
      nmi_n_in <= 1'b0;
      pulse(0, 1'b0, 4'b1000, 7'h0);
      nmi_n_in <= 1'b1;
      wait_done(0, 1);
      chk_exc(8'h01, 1'b1);
      chk_cyc(0, cit_pkg::STAT_ACK_M, 1'b0, cit_pkg::ADDR_NMI_ACK);
      pulse(3, 1'b1, 4'b0000, 7'h0);
      wait_done(1, 0);
   endtask
   task automatic t_traps;
      for (int i = 0; i < 7; i++) begin
         pulse(1, 1'b1, 4'b1101, 7'h40 >> i);
         wait_done(0, 0);
         chk_exc(trap_vec[i], 1'b0);
      end
      pulse(1, 1'b1, 4'b1101, 7'h7f);
      wait_done(0, 0);
      chk_exc(8'h03, 1'b0);
      pulse(1, 1'b1, 4'b1001, 7'h20);
      no_exc();
      pulse(1, 1'b1, 4'b1100, 7'h04);
      no_exc();
      pulse(0, 1'b1, 4'b0010, 7'h0);
      wait_done(0, 0);
      chk_exc(8'h09, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_irq();
      t_nmi();
      t_traps();
      end_sim();
   end
   initial begin
      repeat (6000) @(posedge clk_in);
      n_fail++;
      end_sim();
   end
endmodule // cit_unit_test
